// ===== verilog/cmc_top.sv
// clock multiplier control: wishbone registers, lock tracking, pin claims
//
// Overview of operation
// - init starts only on a written init bit while enable already set
// - locked flag reads 1 from lock until lock loss, re-init or disable, else 0
// - bits 4:2 select the output scaling factor
// - odd-denominator scale codes give an uneven duty cycle
// - bits 1:0 choose the oscillator feeding the multiplier
// - select codes: int x2, ext x2, int x4, ext x4
// - with an x2 selection the scale field is ignored
// - crystal mode takes both oscillator pins
// - capacitor, RC or CMOS mode takes only the output pin
// - with an x4 selection, output is four times input times 1,2/3,1/2,2/5,1/3 or 2/7
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

`include "cmc_regs.svh"

module cmc_top #(
  parameter int SETTLE_CYCLES = `CMC_ENABLE_SETTLE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // analog multiplier side
  input  wire logic        pll_lock_i,
  input  wire logic        ext_osc_valid_i,
  output var  logic        mult_enable_o,
  output var  logic        mult_init_o,
  output var  logic [1:0]  mult_input_select_o,
  output var  logic [2:0]  mult_output_scale_o,
  output var  logic        mult_uneven_duty_o,
  // external oscillator side and interrupt request
  output var  logic [2:0]  ext_osc_mode_o,
  output var  logic [2:0]  ext_osc_freq_range_o,
  output var  logic        osc_pin_in_claim_o,
  output var  logic        osc_pin_out_claim_o,
  output var  logic        osc_pin_digital_o,
  output var  logic        irq_o
);

  // ==========================================================================
  // functions
  // ==========================================================================

  function automatic logic odd_denominator(input logic [2:0] code);
    odd_denominator = (code == 3'h1) || (code == 3'h3) || (code == 3'h5);
  endfunction : odd_denominator

  function automatic logic hit(input logic [9:0] idx, input logic [7:0] reg_idx);
    hit = (idx == {2'h0, reg_idx});
  endfunction : hit

  // ==========================================================================
  // state
  // ==========================================================================

  logic                   enable_q;
  logic                   init_bit_q;
  logic                   locked_q;
  logic [2:0]             scale_q;
  logic [1:0]             select_q;
  logic [2:0]             xmode_q;
  logic [2:0]             xrange_q;
  logic [`CMC_IRQ_W-1:0]  irq_stat_q;
  logic [`CMC_IRQ_W-1:0]  irq_mask_q;
  logic                   ack_q;
  logic [31:0]            rdata_q;
  logic                   lock_s1_q;
  logic                   lock_s2_q;
  logic                   xval_s1_q;
  logic                   xval_s2_q;
  logic                   init_pulse_q;
  logic                   lock_dropped_q;
  logic                   irq_q;
  logic [2:0]             eff_scale_q;
  logic                   uneven_q;
  logic                   pin_in_q;
  logic                   pin_out_q;
  logic                   pin_dig_q;
  cmc_pkg::cmc_state_type state_q;
  cmc_pkg::cmc_state_type state_d;

  // ==========================================================================
  // bus decode
  // ==========================================================================

  wire       req       = wb_cyc_i && wb_stb_i && !ack_q;
  wire       wr        = req && wb_we_i && wb_sel_i[0];
  wire [9:0] idx       = wb_adr_i[11:2];
  wire       hit_mult  = hit(idx, `CMC_IDX_MULT_CTRL);
  wire       hit_xosc  = hit(idx, `CMC_IDX_EXT_OSC_CTRL);
  wire       hit_stat  = hit(idx, `CMC_IDX_IRQ_STATUS);
  wire       hit_mask  = hit(idx, `CMC_IDX_IRQ_MASK);
  wire       wr_mult   = wr && hit_mult;
  wire       wr_xosc   = wr && hit_xosc;
  wire       wr_stat   = wr && hit_stat;
  wire       wr_mask   = wr && hit_mask;
  wire [7:0] wbyte     = wb_dat_i[7:0];

  wire       new_enable = wbyte[`CMC_BIT_ENABLE];

  wire       init_start = wr_mult && wbyte[`CMC_BIT_INIT] && enable_q &&
                          new_enable;

  wire       early_init;
  wire       settled;

  assign early_init = init_start && !settled;

  wire [7:0] mult_view = {enable_q, init_bit_q, locked_q,
                          scale_q, select_q};
  wire [7:0] xosc_view = {xval_s2_q && xmode_q[2] && xmode_q[1],
                          xmode_q, 1'b0, xrange_q};

  wire [31:0] rdata_d =
    hit_mult ? {24'h0, mult_view} :
    hit_xosc ? {24'h0, xosc_view} :
    hit_stat ? {29'h0, irq_stat_q} :
    hit_mask ? {29'h0, irq_mask_q} : 32'h0;

  // ==========================================================================
  // wishbone answer, one cycle after the request
  // ==========================================================================

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= req;
      rdata_q <= req ? rdata_d : 32'h0;
    end
  end

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      xval_s1_q <= 1'b0;
      xval_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= pll_lock_i;
      lock_s2_q <= lock_s1_q;
      xval_s1_q <= ext_osc_valid_i;
      xval_s2_q <= xval_s1_q;
    end
  end

  // ==========================================================================
  // control register
  // ==========================================================================

  localparam logic [7:0] RST_CTRL = `CMC_RST_MULT_CTRL;
  localparam logic [7:0] RST_XOSC = `CMC_RST_EXT_OSC_CTRL;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {enable_q, init_bit_q} <= 2'h0;
      scale_q  <= RST_CTRL[`CMC_SCALE_HI:`CMC_SCALE_LO];
      select_q <= RST_CTRL[`CMC_SEL_HI:`CMC_SEL_LO];
    end else if (wr_mult) begin
      enable_q   <= new_enable;
      init_bit_q <= wbyte[`CMC_BIT_INIT] && enable_q && new_enable;
      scale_q    <= wbyte[`CMC_SCALE_HI:`CMC_SCALE_LO];
      select_q   <= wbyte[`CMC_SEL_HI:`CMC_SEL_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xmode_q  <= RST_XOSC[`CMC_XMODE_HI:`CMC_XMODE_LO];
      xrange_q <= RST_XOSC[`CMC_XRANGE_HI:`CMC_XRANGE_LO];
    end else if (wr_xosc) begin
      xmode_q  <= wbyte[`CMC_XMODE_HI:`CMC_XMODE_LO];
      xrange_q <= wbyte[`CMC_XRANGE_HI:`CMC_XRANGE_LO];
    end
  end

  // ==========================================================================
  // enable settle timer
  // ==========================================================================

  cmc_settle_timer #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .arm_i  (enable_q),
    .done_o (settled)
  );

  // ==========================================================================
  // lock tracking
  // ==========================================================================

  always_comb begin
    state_d = state_q;
    case (state_q)
      cmc_pkg::CMC_ST_OFF: begin
        if (enable_q) begin
          state_d = cmc_pkg::CMC_ST_WARM;
        end
      end
      cmc_pkg::CMC_ST_WARM: begin
        if (init_start) begin
          state_d = cmc_pkg::CMC_ST_LOCKING;
        end
      end
      cmc_pkg::CMC_ST_LOCKING: begin
        // wait for the pll to drop its old lock and regain it
        if (lock_s2_q && lock_dropped_q) begin
          state_d = cmc_pkg::CMC_ST_READY;
        end
      end
      cmc_pkg::CMC_ST_READY: begin
        if (init_start) begin
          state_d = cmc_pkg::CMC_ST_LOCKING;
        end else if (!lock_s2_q) begin
          state_d = cmc_pkg::CMC_ST_LOCKING;
        end
      end
      default: begin
        state_d = cmc_pkg::CMC_ST_OFF;
      end
    endcase
    if (!enable_q || (wr_mult && !new_enable)) begin
      state_d = cmc_pkg::CMC_ST_OFF;
    end
  end

  wire ready_d   = (state_d == cmc_pkg::CMC_ST_READY);
  wire ready_set = ready_d && !locked_q;
  wire lock_lost = (state_q == cmc_pkg::CMC_ST_READY) &&
                   !lock_s2_q && enable_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q      <= cmc_pkg::CMC_ST_OFF;
      locked_q     <= 1'b0;
      init_pulse_q <= 1'b0;
      lock_dropped_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      // locked flag follows the lock state
      locked_q     <= ready_d;
      init_pulse_q <= init_start;
      // old lock must be seen low before relock
      lock_dropped_q <= !init_start && (lock_dropped_q || !lock_s2_q);
    end
  end

  // ==========================================================================
  // interrupts
  // ==========================================================================

  wire [`CMC_IRQ_W-1:0] irq_evt = {early_init, lock_lost, ready_set};
  wire [`CMC_IRQ_W-1:0] irq_clr = wr_stat ? wbyte[`CMC_IRQ_W-1:0] :
                                            `CMC_RST_IRQ;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= `CMC_RST_IRQ;
      irq_mask_q <= `CMC_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      if (wr_mask) begin
        irq_mask_q <= wbyte[`CMC_IRQ_W-1:0];
      end
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================================
  // multiplier settings toward the analog side
  // ==========================================================================

  wire       x4_sel    = select_q[`CMC_SEL_X4_BIT];
  wire [2:0] eff_scale = x4_sel ? scale_q : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eff_scale_q <= 3'h0;
      uneven_q    <= 1'b0;
    end else begin
      eff_scale_q <= eff_scale;
      uneven_q    <= enable_q && odd_denominator(eff_scale);
    end
  end

  // ==========================================================================
  // oscillator pin claims
  // ==========================================================================

  logic claim_in;
  logic claim_out;
  logic claim_dig;

  cmc_pin_claim u_pins (
    .xmode_i         (xmode_q),
    .claim_in_pin_o  (claim_in),
    .claim_out_pin_o (claim_out),
    .digital_in_o    (claim_dig)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_in_q  <= 1'b0;
      pin_out_q <= 1'b0;
      pin_dig_q <= 1'b0;
    end else begin
      pin_in_q  <= claim_in;
      pin_out_q <= claim_out;
      pin_dig_q <= claim_dig;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================

  assign wb_dat_o             = rdata_q;
  assign wb_ack_o             = ack_q;
  assign mult_enable_o        = enable_q;
  assign mult_init_o          = init_pulse_q;
  assign mult_input_select_o  = select_q;
  assign mult_output_scale_o  = eff_scale_q;
  assign mult_uneven_duty_o   = uneven_q;
  assign ext_osc_mode_o       = xmode_q;
  assign ext_osc_freq_range_o = xrange_q;
  assign osc_pin_in_claim_o   = pin_in_q;
  assign osc_pin_out_claim_o  = pin_out_q;
  assign osc_pin_digital_o    = pin_dig_q;
  assign irq_o                = irq_q;

endmodule : cmc_top

`default_nettype wire

// ===== verilog/cmc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// register indexes; byte address is four times the index
`define CMC_IDX_MULT_CTRL     8'h97
`define CMC_IDX_EXT_OSC_CTRL  8'h9f
`define CMC_IDX_IRQ_STATUS    8'ha0
`define CMC_IDX_IRQ_MASK      8'ha1

// multiplier control fields
`define CMC_BIT_ENABLE        7
`define CMC_BIT_INIT          6
`define CMC_BIT_LOCKED        5
`define CMC_SCALE_HI          4
`define CMC_SCALE_LO          2
`define CMC_SEL_HI            1
`define CMC_SEL_LO            0
`define CMC_SEL_X4_BIT        1
`define CMC_SEL_EXT_BIT       0

// external oscillator control fields
`define CMC_BIT_XVALID        7
`define CMC_XMODE_HI          6
`define CMC_XMODE_LO          4
`define CMC_XRANGE_HI         2
`define CMC_XRANGE_LO         0

// interrupt status and mask bits
`define CMC_IRQ_READY         0
`define CMC_IRQ_LOCK_LOST     1
`define CMC_IRQ_EARLY_INIT    2
`define CMC_IRQ_W             3

// reset values
`define CMC_RST_MULT_CTRL     8'h00
`define CMC_RST_EXT_OSC_CTRL  8'h00
`define CMC_RST_IRQ           3'h0

// timing
`define CMC_CLK_MHZ           10
`define CMC_ENABLE_SETTLE_NS  5000
`define CMC_ENABLE_SETTLE_CYC \
  ((`CMC_ENABLE_SETTLE_NS * `CMC_CLK_MHZ + 999) / 1000)

`endif

// ===== verilog/cmc_pkg.sv
// types shared by the clock multiplier control block
package cmc_pkg;

  typedef enum logic [1:0] {
    CMC_ST_OFF,
    CMC_ST_WARM,
    CMC_ST_LOCKING,
    CMC_ST_READY
  } cmc_state_type;

  typedef enum logic [2:0] {
    CMC_XM_OFF0,
    CMC_XM_OFF1,
    CMC_XM_CMOS,
    CMC_XM_CMOS_DIV2,
    CMC_XM_RC,
    CMC_XM_CAP,
    CMC_XM_XTAL,
    CMC_XM_XTAL_DIV2
  } cmc_xmode_type;

endpackage : cmc_pkg

// ===== verilog/cmc_settle_timer.sv
// counts clock cycles while armed and flags when the count has elapsed
`timescale 1ns/10ps
`default_nettype none

module cmc_settle_timer #(
  parameter int CYCLES = 50
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic arm_i,
  output var  logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;

  // restarts from zero whenever arm drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !arm_i) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(CYCLES)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done_o = arm_i && (cnt_q == CW'(CYCLES));

endmodule : cmc_settle_timer

`default_nettype wire

// ===== verilog/cmc_pin_claim.sv
// decodes which oscillator pins the external oscillator mode takes over
`timescale 1ns/10ps
`default_nettype none

module cmc_pin_claim (
  input  wire logic [2:0] xmode_i,
  output var  logic       claim_in_pin_o,
  output var  logic       claim_out_pin_o,
  output var  logic       digital_in_o
);

  cmc_pkg::cmc_xmode_type mode;

  assign mode = cmc_pkg::cmc_xmode_type'(xmode_i);

  always_comb begin
    claim_in_pin_o  = 1'b0;
    claim_out_pin_o = 1'b0;
    digital_in_o    = 1'b0;
    case (mode)
      cmc_pkg::CMC_XM_XTAL, cmc_pkg::CMC_XM_XTAL_DIV2: begin
        claim_in_pin_o  = 1'b1;
        claim_out_pin_o = 1'b1;
      end
      cmc_pkg::CMC_XM_RC, cmc_pkg::CMC_XM_CAP: begin
        claim_out_pin_o = 1'b1;
      end
      cmc_pkg::CMC_XM_CMOS, cmc_pkg::CMC_XM_CMOS_DIV2: begin
        claim_out_pin_o = 1'b1;
        digital_in_o    = 1'b1;
      end
      default: begin
        claim_in_pin_o  = 1'b0;
      end
    endcase
  end

endmodule : cmc_pin_claim

`default_nettype wire

// ===== verification/cmc_top_properties.sv
// checker on the ports of the clock multiplier control top
`timescale 1ns/10ps
`default_nettype none

module cmc_top_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        mult_enable_o,
  input wire logic        mult_init_o,
  input wire logic [1:0]  mult_input_select_o,
  input wire logic [2:0]  mult_output_scale_o,
  input wire logic        mult_uneven_duty_o,
  input wire logic [2:0]  ext_osc_mode_o,
  input wire logic        osc_pin_in_claim_o,
  input wire logic        osc_pin_out_claim_o
);
  // ==========================================
  // helpers
  wire logic       ctl_hit = wb_ack_o && wb_adr_i == 12'h25c;
  wire logic       wr_ctl  = ctl_hit && wb_we_i && wb_sel_i[0];
  wire logic       rd_ctl  = ctl_hit && !wb_we_i;
  wire logic [2:0] sc      = mult_output_scale_o;
  wire logic       odd_sc  = mult_enable_o && sc inside {3'h1, 3'h3, 3'h5};

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================
  // bus handshake
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered in one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");

  // ==========================================
  // multiplier control
  property p_init_cause;
    mult_init_o |-> wr_ctl && wb_dat_i[7:6] == 2'b11 && $past(mult_enable_o);
  endproperty
  a_init_cause: assert property (p_init_cause)
    else $error("init pulse without enabled init write");
  property p_rdy_en; rd_ctl && wb_dat_o[5] |-> mult_enable_o; endproperty
  a_rdy_en: assert property (p_rdy_en)
    else $error("locked flag read while disabled");
  property p_sel_wr;
    wr_ctl |-> mult_input_select_o == wb_dat_i[1:0]
      && mult_enable_o == wb_dat_i[7];
  endproperty
  a_sel_wr: assert property (p_sel_wr)
    else $error("select or enable not taken from write");
  property p_scale_x2; !mult_input_select_o[1] |=> sc == 3'h0; endproperty
  a_scale_x2: assert property (p_scale_x2)
    else $error("scale not ignored with x2 select");
  property p_scale_x4; wr_ctl && wb_dat_i[1] |=> sc == $past(wb_dat_i[4:2]);
  endproperty
  a_scale_x4: assert property (p_scale_x4)
    else $error("scale field not applied with x4 select");
  property p_duty;
    $stable(sc) && $stable(mult_enable_o) |-> mult_uneven_duty_o == odd_sc;
  endproperty
  a_duty: assert property (p_duty)
    else $error("uneven duty flag wrong for scale");

  // ==========================================
  // oscillator pins
  property p_pin_in;
    $stable(ext_osc_mode_o) |->
      osc_pin_in_claim_o == (ext_osc_mode_o[2:1] == 2'b11);
  endproperty
  a_pin_in: assert property (p_pin_in)
    else $error("input pin claim wrong for mode");
  property p_pin_out;
    $stable(ext_osc_mode_o) |->
      osc_pin_out_claim_o == (ext_osc_mode_o[2:1] != 2'b00);
  endproperty
  a_pin_out: assert property (p_pin_out)
    else $error("output pin claim wrong for mode");
endmodule : cmc_top_properties

`default_nettype wire

// ===== verification/cmc_pll_model.sv
// behavioural phase-locked loop and crystal oscillator
`timescale 1ns/10ps
`default_nettype none

module cmc_pll_model #(
  parameter int LOCK_CYC = 6,
  parameter int XTAL_CYC = 10
) (
  input  wire logic       clk_i,
  input  wire logic       enable_i,
  input  wire logic       init_i,
  input  wire logic       unlock_i,
  input  wire logic [2:0] xmode_i,
  output var  logic       lock_o,
  output var  logic       xtal_valid_o
);
  int   lock_cnt = 0;
  int   xtal_cnt = 0;
  logic armed    = 1'b0;

  always @(posedge clk_i) begin
    if (!enable_i)
      armed <= 1'b0;
    else if (init_i)
      armed <= 1'b1;
    if (!enable_i || init_i || unlock_i)
      lock_cnt <= 0;
    else if (armed && lock_cnt < LOCK_CYC)
      lock_cnt <= lock_cnt + 1;
  end

  always @(posedge clk_i) begin
    if (xmode_i[2:1] != 2'b11)
      xtal_cnt <= 0;
    else if (xtal_cnt < XTAL_CYC)
      xtal_cnt <= xtal_cnt + 1;
  end

  assign lock_o       = lock_cnt == LOCK_CYC;
  assign xtal_valid_o = xtal_cnt == XTAL_CYC;
endmodule : cmc_pll_model

`default_nettype wire

// ===== verification/cmc_top_bench.sv
// self-checking bench for the clock multiplier control block
`timescale 1ns/10ps
`default_nettype none

module cmc_top_bench;
  localparam int          SETTLE = 4;
  localparam int          LIMIT  = 20000;
  localparam logic [11:0] A_CTL  = 12'h25c;
  localparam logic [11:0] A_OSC  = 12'h27c;
  localparam logic [11:0] A_STA  = 12'h280;
  localparam logic [11:0] A_MSK  = 12'h284;

  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        unlock   = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, pll_lock_i, ext_osc_valid_i, irq_o;
  logic        mult_enable_o, mult_init_o, mult_uneven_duty_o;
  logic        osc_pin_in_claim_o, osc_pin_out_claim_o, osc_pin_digital_o;
  logic [1:0]  mult_input_select_o;
  logic [2:0]  mult_output_scale_o, ext_osc_mode_o, ext_osc_freq_range_o;
  logic [7:0]  rd       = 8'h00;
  logic [11:0] regs [5] = '{12'h25c, 12'h27c, 12'h280, 12'h284, 12'h100};
  int          n_fail     = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int          n_init     = 0;
  int          n0;

  always #50 clk_i = ~clk_i;

  cmc_top #(.SETTLE_CYCLES(SETTLE)) DUT (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_lock_i, .ext_osc_valid_i,
    .mult_enable_o, .mult_init_o, .mult_input_select_o,
    .mult_output_scale_o, .mult_uneven_duty_o, .ext_osc_mode_o,
    .ext_osc_freq_range_o, .osc_pin_in_claim_o, .osc_pin_out_claim_o,
    .osc_pin_digital_o, .irq_o
  );

  cmc_pll_model u_pll (
    .clk_i, .enable_i(mult_enable_o), .init_i(mult_init_o),
    .unlock_i(unlock), .xmode_i(ext_osc_mode_o),
    .lock_o(pll_lock_i), .xtal_valid_o(ext_osc_valid_i)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle, entered just after a rising edge
  task automatic wb_access(input logic w, input logic [11:0] a,
                           input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_access

  task automatic poll_lock;
    rd = 8'h00;
    for (int i = 0; i < 40 && !rd[5]; i++)
      wb_access(1'b0, A_CTL, 8'h00);
  endtask : poll_lock

  always @(posedge clk_i) begin
    cycles++;
    if (mult_init_o === 1'b1)
      n_init++;
    if (cycles == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("outs", 16'h0, 16'({mult_enable_o, mult_init_o, irq_o,
      mult_output_scale_o, ext_osc_mode_o, osc_pin_out_claim_o}));
    wb_access(1'b1, 12'h100, 8'hff);
    foreach (regs[i]) begin
      wb_access(1'b0, regs[i], 8'h00);
      check("reset", 16'h0, 16'(rd));
    end
    wb_access(1'b1, A_MSK, 8'h07);
    for (int m = 0; m < 8; m++) begin
      wb_access(1'b1, A_OSC, 8'(m * 16 + 5));
      repeat (14) @(posedge clk_i);
      wb_access(1'b0, A_OSC, 8'h00);
      check("osc", 16'({m >= 6, 3'(m), 4'h5}), 16'(rd));
      check("pin_in", 16'(m >= 6), 16'(osc_pin_in_claim_o));
      check("pin_out", 16'(m >= 2), 16'(osc_pin_out_claim_o));
      check("pin_dig", 16'(m == 2 || m == 3), 16'(osc_pin_digital_o));
      check("range", 16'h5, 16'(ext_osc_freq_range_o));
    end
    for (int s = 0; s < 32; s++) begin
      wb_access(1'b1, A_CTL, 8'h80 | 8'(s));
      wb_access(1'b0, A_CTL, 8'h00);
      check("ctl", 16'h80 | 16'(s), 16'(rd));
      check("sel", 16'(s[1:0]), 16'(mult_input_select_o));
      check("scale", s[1] ? 16'(s[4:2]) : 16'h0,
            16'(mult_output_scale_o));
      check("duty", 16'(s[1] && s[4:2] inside {3'h1, 3'h3, 3'h5}),
            16'(mult_uneven_duty_o));
    end
    wb_access(1'b1, A_CTL, 8'h00);
    n0 = n_init;
    wb_access(1'b1, A_CTL, 8'h40);
    wb_access(1'b0, A_CTL, 8'h00);
    check("init_off", 16'h0, 16'(rd));
    check("n_init", 16'(n0), 16'(n_init));
    wb_access(1'b1, A_CTL, 8'h03);
    wb_access(1'b1, A_CTL, 8'h83);
    repeat (SETTLE + 2) @(posedge clk_i);
    wb_access(1'b1, A_CTL, 8'hc3);
    wb_access(1'b0, A_CTL, 8'h00);
    check("init_rd", 16'hc3, 16'(rd));
    check("n_init", 16'(n0 + 1), 16'(n_init));
    poll_lock();
    check("ready", 16'he3, 16'(rd));
    wb_access(1'b0, A_STA, 8'h00);
    check("sta_rdy", 16'h01, 16'(rd));
    repeat (2) @(posedge clk_i);
    check("irq_on", 16'h1, 16'(irq_o));
    wb_access(1'b1, A_STA, 8'h01);
    repeat (2) @(posedge clk_i);
    check("irq_off", 16'h0, 16'(irq_o));
    wb_access(1'b1, A_MSK, 8'h01);
    unlock <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb_access(1'b0, A_CTL, 8'h00);
    check("lost", 16'h0, 16'(rd[5]));
    wb_access(1'b0, A_STA, 8'h00);
    check("sta_lost", 16'h02, 16'(rd));
    check("irq_mask", 16'h0, 16'(irq_o));
    wb_access(1'b1, A_MSK, 8'h02);
    repeat (2) @(posedge clk_i);
    check("irq_unmask", 16'h1, 16'(irq_o));
    unlock <= 1'b0;
    poll_lock();
    check("relock", 16'h1, 16'(rd[5]));
    wb_access(1'b1, A_STA, 8'h07);
    wb_access(1'b1, A_CTL, 8'hc3);
    wb_access(1'b0, A_CTL, 8'h00);
    check("reinit", 16'h0, 16'(rd[5]));
    poll_lock();
    wb_access(1'b1, A_CTL, 8'h00);
    wb_access(1'b0, A_CTL, 8'h00);
    check("disable", 16'h0, 16'(rd));
    wb_access(1'b1, A_CTL, 8'h80);
    wb_access(1'b1, A_CTL, 8'hc0);
    wb_access(1'b0, A_STA, 8'h00);
    check("early", 16'h1, 16'(rd[2]));
    complete_run();
  end
endmodule : cmc_top_bench

bind cmc_top cmc_top_properties u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .mult_enable_o, .mult_init_o,
  .mult_input_select_o, .mult_output_scale_o, .mult_uneven_duty_o,
  .ext_osc_mode_o, .osc_pin_in_claim_o, .osc_pin_out_claim_o
);

`default_nettype wire
